// ---- hdl/arb_level_pick.sv ----
/*
  Picks the winning request level, searching downward from a given
  top level with wrap-around. Pure combinational; used by the arbiter.
*/
`timescale 1ns/100ps
`default_nettype none
module arb_level_pick
  import vme_sysctl_pkg::*;
(
  input  wire logic [NUM_LEVELS-1:0] i_req,
  input  wire logic [LVL_W-1:0]      i_top,
  output logic                       o_valid,
  output logic [LVL_W-1:0]           o_level
);
  logic [LVL_W-1:0] cand;

  always_comb begin
    o_valid = 1'b0;
    o_level = i_top;
    cand    = i_top;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      cand = i_top - LVL_W'(i);
      if (!o_valid && i_req[cand]) begin
        o_valid = 1'b1;
        o_level = cand;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hdl/vme_sysctl_pkg.sv ----
/*
  Constants, register map and state types for the backplane system
  controller. Assumes a 200 MHz reference clock in the including design.
*/
package vme_sysctl_pkg;
  localparam int REF_CLK_MHZ = 200;
  localparam int SYSCLK_MHZ  = 16;
  localparam int NUM_LEVELS  = 4;
  localparam int LVL_W       = 2;

  // Fractional divider: toggle when the phase wraps past the modulus
  localparam logic [8:0] SYSCLK_STEP = 9'(2 * SYSCLK_MHZ);
  localparam logic [8:0] SYSCLK_MOD  = 9'(REF_CLK_MHZ);

  localparam int TMR_W          = 27;
  localparam int SYSFAIL_MS     = 500;
  localparam int SYSFAIL_CYC    = SYSFAIL_MS * 1000 * REF_CLK_MHZ;
  localparam int PU_RESET_MS    = 200;
  localparam int PU_RESET_CYC   = PU_RESET_MS * 1000 * REF_CLK_MHZ;
  localparam int PD_RESET_US    = 200;
  localparam int PD_RESET_CYC   = PD_RESET_US * REF_CLK_MHZ;
  localparam int WD_BASE_US     = 4;
  localparam int WD_BASE_CYC    = WD_BASE_US * REF_CLK_MHZ;
  localparam int WD_CNT_W       = 21;
  localparam logic [3:0] WD_SEL_MAX = 4'hB;

  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATE      = 4'h8;

  localparam int NUM_EVENTS    = 4;
  localparam int EV_WD_TIMEOUT = 0;
  localparam int EV_ACFAIL     = 1;
  localparam int EV_BUTTON     = 2;
  localparam int EV_POWER_OK   = 3;
  localparam logic [NUM_EVENTS-1:0] IRQ_MASK_RST = 4'h0;

  localparam int ST_GRANT_LSB = 0;
  localparam int ST_BBSY      = 4;
  localparam int ST_WD_ERR    = 5;
  localparam int ST_ACFAIL    = 6;
  localparam int ST_SYSRESET  = 7;
  localparam int ST_SYSFAIL   = 8;
  localparam int ST_RR_MODE   = 9;
  localparam int ST_PFSEL_LSB = 10;
  localparam int ST_WDSEL_LSB = 12;

  // Bit positions in the synchronised input bundle
  localparam int IN_BR_LSB  = 0;
  localparam int IN_BBSY    = 4;
  localparam int IN_AS      = 5;
  localparam int IN_DS0     = 6;
  localparam int IN_DS1     = 7;
  localparam int IN_DTACK   = 8;
  localparam int IN_BERR    = 9;
  localparam int IN_PF      = 10;
  localparam int IN_BUTTON  = 11;
  localparam int IN_RR_MODE = 12;
  localparam int IN_PFSEL   = 13;
  localparam int IN_WDSEL   = 15;
  localparam int NUM_IN     = 19;
  // Idle pin levels: active-low lines rest high, so no false edge
  localparam logic [NUM_IN-1:0] IN_IDLE = 19'h00BFF;

  localparam logic [1:0] PF_SEL_HIGH = 2'h1;
  localparam logic [1:0] PF_SEL_LOW  = 2'h2;

  typedef enum logic [1:0] {ARB_IDLE, ARB_GRANT, ARB_BUSY} arb_state_e;
  typedef enum logic [1:0] {WD_IDLE, WD_RUN, WD_WAIT, WD_ERR} wd_state_e;
endpackage

// ---- hdl/vme_system_controller.sv ----
/*
  Backplane system controller: four-level bus arbiter, bus watchdog,
  power-fail sequencing, reset/fail line timing, system clock and a
  small register port with interrupt. Assumes open-drain bus lines are
  resolved outside from the output enables, and that jumper inputs are
  static while running.
*/
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1: Jumper picks fixed priority or round robin
// R2: Fixed mode grants highest pending level
// R3: Round robin rotates priority to spread load
// R4: Four request levels, grant on winner's line
// R5: Power-fail input high, low or ignored
// R6: Power-fail raises ACFAIL, times SYSRESET
// R7: SYSFAIL held 500 ms after events
// R8: Watchdog starts on AS or DS assertion
// R9: DTACK or BERR stops watchdog cleanly
// R10: Timeout drives BERR until strobes released
// R11: Period 4 to 8192 us, powers two
// R12: Free-running symmetrical 16 MHz clock out (here high 6, low 6 or 7 cycles)
// R13: After grant, priority moves below winner
// R14: Hold grant, re-arbitrate after bus released
module vme_system_controller
  import vme_sysctl_pkg::*;
#(
  parameter int SYSFAIL_CYCLES  = SYSFAIL_CYC,
  parameter int PU_RESET_CYCLES = PU_RESET_CYC,
  parameter int PD_RESET_CYCLES = PD_RESET_CYC,
  parameter int WD_BASE_CYCLES  = WD_BASE_CYC
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic [NUM_LEVELS-1:0] i_bus_req_n,
  input  wire logic                  i_bus_busy_n,
  input  wire logic                  i_addr_strobe_n,
  input  wire logic [1:0]            i_data_strobe_n,
  input  wire logic                  i_dtack_n,
  input  wire logic                  i_berr_n,
  input  wire logic                  i_power_fail,
  input  wire logic                  i_reset_button_n,
  input  wire logic                  i_rr_mode,
  input  wire logic [1:0]            i_pf_sel,
  input  wire logic [3:0]            i_wd_sel,
  input  wire logic [ADDR_W-1:0]     i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic [31:0]                o_rdata,
  output logic                       o_irq,
  output logic                       o_sysclk,
  output logic [NUM_LEVELS-1:0]      o_bus_grant_n,
  output logic                       o_berr_n,
  output logic                       o_berr_oe,
  output logic                       o_acfail_n,
  output logic                       o_acfail_oe,
  output logic                       o_sysreset_n,
  output logic                       o_sysreset_oe,
  output logic                       o_sysfail_n,
  output logic                       o_sysfail_oe,
  output logic                       o_berr_led,
  output logic                       o_sysfail_led
);
  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] sync1;
  logic [NUM_IN-1:0] sync2;
  logic [NUM_IN-1:0] sync3;
  logic [NUM_IN-1:0] filt;

  assign raw_in = {i_wd_sel, i_pf_sel, i_rr_mode, i_reset_button_n,
                   i_power_fail, i_berr_n, i_dtack_n, i_data_strobe_n,
                   i_addr_strobe_n, i_bus_busy_n, i_bus_req_n};

  // Three stages per pin; a level is accepted once stages 2 and 3 agree
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : gen_sync
      always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
          sync1[g] <= IN_IDLE[g];
          sync2[g] <= IN_IDLE[g];
          sync3[g] <= IN_IDLE[g];
          filt[g]  <= IN_IDLE[g];
        end else begin
          sync1[g] <= raw_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            filt[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  logic [NUM_LEVELS-1:0] req;
  logic                  bus_busy;
  logic                  strobe;
  logic                  slave_ack;
  logic                  button;
  logic                  rr_mode;
  logic [1:0]            pf_sel;
  logic [3:0]            wd_sel;
  logic                  pf_qual;

  assign req       = ~filt[IN_BR_LSB +: NUM_LEVELS];
  assign bus_busy  = ~filt[IN_BBSY];
  assign strobe    = ~filt[IN_AS] | ~filt[IN_DS0] | ~filt[IN_DS1]; // R8
  assign slave_ack = ~filt[IN_DTACK] | ~filt[IN_BERR]; // R9
  assign button    = ~filt[IN_BUTTON];
  assign rr_mode   = filt[IN_RR_MODE];
  assign pf_sel    = filt[IN_PFSEL +: 2];
  assign wd_sel    = filt[IN_WDSEL +: 4];

  // Any other selection disables the monitor input
  assign pf_qual = (pf_sel == PF_SEL_HIGH) ? filt[IN_PF]
                 : (pf_sel == PF_SEL_LOW)  ? ~filt[IN_PF] : 1'b0; // R5

  // Open-drain lines only ever pull low
  logic low_level;
  always_ff @(posedge i_ref_clk) begin
    low_level <= 1'b0;
  end
  assign o_berr_n     = low_level;
  assign o_acfail_n   = low_level;
  assign o_sysreset_n = low_level;
  assign o_sysfail_n  = low_level;

  // System clock. 200/16 is not whole, so edges carry one cycle of
  // jitter; the average period stays exact, high is 6 cycles, low 6 or 7.
  logic [8:0] clk_phase;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      clk_phase <= 9'h000;
      o_sysclk  <= 1'b0;
    end else if (clk_phase + SYSCLK_STEP >= SYSCLK_MOD) begin
      clk_phase <= clk_phase + SYSCLK_STEP - SYSCLK_MOD; // R12
      o_sysclk  <= ~o_sysclk; // R12
    end else begin
      clk_phase <= clk_phase + SYSCLK_STEP;
    end
  end

  // Arbiter
  arb_state_e       arb_state;
  logic [LVL_W-1:0] rr_top;
  logic [LVL_W-1:0] pick_top;
  logic [LVL_W-1:0] pick_level;
  logic             pick_valid;
  logic [LVL_W-1:0] owner;

  assign pick_top = rr_mode ? rr_top : LVL_W'(NUM_LEVELS - 1); // R1 R2

  arb_level_pick u_pick (
    .i_req   (req),
    .i_top   (pick_top),
    .o_valid (pick_valid),
    .o_level (pick_level)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      arb_state     <= ARB_IDLE;
      rr_top        <= LVL_W'(NUM_LEVELS - 1);
      owner         <= '0;
      o_bus_grant_n <= '1;
    end else begin
      unique case (arb_state)
        ARB_IDLE: begin
          if (pick_valid && !bus_busy) begin // R14
            owner                     <= pick_level;
            o_bus_grant_n[pick_level] <= 1'b0; // R4
            rr_top                    <= pick_level - 1'b1; // R3 R13
            arb_state                 <= ARB_GRANT;
          end
        end
        ARB_GRANT: begin
          if (bus_busy) begin
            o_bus_grant_n <= '1;
            arb_state     <= ARB_BUSY;
          end else if (!req[owner]) begin
            o_bus_grant_n <= '1;
            arb_state     <= ARB_IDLE;
          end
        end
        ARB_BUSY: begin
          if (!bus_busy) begin // R14
            arb_state <= ARB_IDLE;
          end
        end
      endcase
    end
  end

  // Bus watchdog
  wd_state_e           wd_state;
  logic [WD_CNT_W-1:0] wd_cnt;
  logic [WD_CNT_W-1:0] wd_limit;
  logic [3:0]          wd_shift;
  logic                wd_fire;

  assign wd_shift = (wd_sel > WD_SEL_MAX) ? WD_SEL_MAX : wd_sel;
  assign wd_limit = WD_CNT_W'(WD_BASE_CYCLES) << wd_shift; // R11
  assign wd_fire  = (wd_state == WD_RUN) && !slave_ack && strobe &&
                    (wd_cnt >= wd_limit - 1'b1);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wd_state  <= WD_IDLE;
      wd_cnt    <= '0;
      o_berr_oe <= 1'b0;
    end else begin
      unique case (wd_state)
        WD_IDLE: begin
          wd_cnt <= '0;
          if (strobe) begin
            wd_state <= WD_RUN; // R8
          end
        end
        WD_RUN: begin
          wd_cnt <= wd_cnt + 1'b1;
          if (slave_ack) begin
            wd_state <= WD_WAIT; // R9
          end else if (!strobe) begin
            wd_state <= WD_IDLE;
          end else if (wd_fire) begin
            wd_state  <= WD_ERR;
            o_berr_oe <= 1'b1; // R10
          end
        end
        WD_WAIT: begin
          if (!strobe) begin
            wd_state <= WD_IDLE;
          end
        end
        WD_ERR: begin
          // DTACK is ignored here; only strobe release ends the error
          if (!strobe) begin
            wd_state  <= WD_IDLE;
            o_berr_oe <= 1'b0; // R10
          end
        end
      endcase
    end
  end

  // Power-fail, reset and fail line timing
  logic             pf_prev;
  logic             button_prev;
  logic [TMR_W-1:0] pd_cnt;
  logic             pd_reached;
  logic [TMR_W-1:0] pu_cnt;
  logic [TMR_W-1:0] sf_cnt;
  logic             acfail_rise;
  logic             pf_clear;
  logic             button_press;

  assign acfail_rise  = pf_qual & ~pf_prev;
  assign pf_clear     = ~pf_qual & pf_prev;
  assign button_press = button & ~button_prev;
  assign pd_reached   = (pd_cnt >= TMR_W'(PD_RESET_CYCLES));

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pf_prev     <= 1'b0;
      button_prev <= 1'b0;
      o_acfail_oe <= 1'b0;
    end else begin
      pf_prev     <= pf_qual;
      button_prev <= button;
      o_acfail_oe <= pf_qual; // R6
    end
  end

  // Power-down: SYSRESET follows ACFAIL after a fixed lead time
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pd_cnt <= '0;
    end else if (!pf_qual) begin
      pd_cnt <= '0;
    end else if (!pd_reached) begin
      pd_cnt <= pd_cnt + 1'b1; // R6
    end
  end

  // Power-up, restore and pushbutton: SYSRESET held for a fixed time
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pu_cnt <= TMR_W'(PU_RESET_CYCLES);
    end else if (pf_clear || button) begin
      pu_cnt <= TMR_W'(PU_RESET_CYCLES); // R6
    end else if (pu_cnt != '0) begin
      pu_cnt <= pu_cnt - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_sysreset_oe <= 1'b1;
    end else begin
      o_sysreset_oe <= pd_reached || (pu_cnt != '0) || button; // R6
    end
  end

  // Reset itself stands for the power-up event
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sf_cnt <= TMR_W'(SYSFAIL_CYCLES); // R7
    end else if (acfail_rise || button_press) begin
      sf_cnt <= TMR_W'(SYSFAIL_CYCLES); // R7
    end else if (sf_cnt != '0) begin
      sf_cnt <= sf_cnt - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_sysfail_oe  <= 1'b1;
      o_sysfail_led <= 1'b1;
      o_berr_led    <= 1'b0;
    end else begin
      o_sysfail_oe  <= (sf_cnt != '0); // R7
      o_sysfail_led <= (sf_cnt != '0);
      o_berr_led    <= ~filt[IN_BERR];
    end
  end

  // Registers and interrupt
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_EVENTS-1:0] irq_status;
  logic [NUM_EVENTS-1:0] irq_mask;
  logic [NUM_EVENTS-1:0] clear_bits;
  logic [15:0]           state_word;

  assign events[EV_WD_TIMEOUT] = wd_fire;
  assign events[EV_ACFAIL]     = acfail_rise;
  assign events[EV_BUTTON]     = button_press;
  assign events[EV_POWER_OK]   = pf_clear;

  assign clear_bits = (i_wr && i_addr == REG_IRQ_STATUS)
                    ? i_wdata[NUM_EVENTS-1:0] : '0;

  assign state_word = {wd_sel, pf_sel, rr_mode, o_sysfail_oe,
                       o_sysreset_oe, o_acfail_oe, o_berr_oe, bus_busy,
                       ~o_bus_grant_n};

  // A new event outranks a same-cycle clear so it is never lost
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~clear_bits) | events;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (i_wr && i_addr == REG_IRQ_MASK) begin
      irq_mask <= i_wdata[NUM_EVENTS-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        REG_IRQ_STATUS: o_rdata <= 32'(irq_status);
        REG_IRQ_MASK:   o_rdata <= 32'(irq_mask);
        REG_STATE:      o_rdata <= 32'(state_word);
        default:        o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// ---- verif/vme_bus_partner.sv ----
/*
  Backplane partner: four requesting masters and one slave.
  Assumes the controller's grants and error enable come back in.
*/
`timescale 1ns/100ps
`default_nettype none
module vme_bus_partner (
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [3:0] i_want,
  input  wire logic [3:0] i_grant_n,
  input  wire logic       i_start,
  input  wire logic [3:0] i_ack_dly,
  input  wire logic       i_berr_oe,
  output logic [3:0]      o_req_n,
  output logic            o_busy_n,
  output logic            o_as_n,
  output logic [1:0]      o_ds_n,
  output logic            o_dtack_n,
  output logic            o_berr_n,
  output logic            o_won,
  output logic [1:0]      o_won_lvl
);
  logic [3:0] pend;
  logic [2:0] hold;
  logic [3:0] cnt;
  assign o_req_n  = ~pend;
  // Error line has a pull-up, so only the controller pulls it low
  assign o_berr_n = ~i_berr_oe;
  always_ff @(posedge i_ref_clk) begin
    o_won <= 1'b0;
    if (i_sys_rst) begin
      pend     <= 4'h0;
      o_busy_n <= 1'b1;
      hold     <= 3'h0;
    end else if (o_busy_n && hold == 3'h0 && |(~i_grant_n & pend)) begin
      pend      <= (pend | i_want) & i_grant_n;
      o_busy_n  <= 1'b0;
      hold      <= 3'h7;
      o_won     <= 1'b1;
      o_won_lvl <= !i_grant_n[3] ? 2'h3 : !i_grant_n[2] ? 2'h2 :
                   !i_grant_n[1] ? 2'h1 : 2'h0;
    end else begin
      pend <= pend | i_want;
      if (hold != 3'h0)
        hold <= hold - 3'h1;
      else
        o_busy_n <= 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_as_n    <= 1'b1;
      o_ds_n    <= 2'h3;
      o_dtack_n <= 1'b1;
      cnt       <= 4'h0;
    end else if (i_start) begin
      o_as_n <= 1'b0;
      o_ds_n <= 2'h2;
      cnt    <= 4'h0;
    end else if (!o_as_n) begin
      cnt <= cnt + 4'h1;
      if (i_ack_dly != 4'h0 && cnt == i_ack_dly)
        o_dtack_n <= 1'b0;
      if (!o_dtack_n || !o_berr_n) begin
        o_as_n <= 1'b1;
        o_ds_n <= 2'h3;
      end
    end else
      o_dtack_n <= 1'b1;
  end
endmodule
`default_nettype wire

// ---- verif/vme_sysctl_checker.sv ----
/*
  Port assertions for the backplane system controller.
  Assumes the bind below and the shortened counts handed to it.
*/
`timescale 1ns/100ps
`default_nettype none
module vme_sysctl_checker
  import vme_sysctl_pkg::*;
#(
  parameter int SYSFAIL_CYCLES  = SYSFAIL_CYC,
  parameter int PU_RESET_CYCLES = PU_RESET_CYC
) (
  input wire logic                  i_ref_clk,
  input wire logic                  i_sys_rst,
  input wire logic [NUM_LEVELS-1:0] i_bus_req_n,
  input wire logic                  i_addr_strobe_n,
  input wire logic [1:0]            i_data_strobe_n,
  input wire logic                  i_power_fail,
  input wire logic [1:0]            i_pf_sel,
  input wire logic                  i_rd,
  input wire logic [31:0]           o_rdata,
  input wire logic                  o_sysclk,
  input wire logic [NUM_LEVELS-1:0] o_bus_grant_n,
  input wire logic                  o_berr_oe,
  input wire logic                  o_acfail_oe,
  input wire logic                  o_sysreset_oe,
  input wire logic                  o_sysfail_oe
);
  logic stb;
  logic pf_q;
  int   fail_cnt;
  int   rst_cnt;
  assign stb  = !i_addr_strobe_n || i_data_strobe_n != 2'h3;
  assign pf_q = (i_pf_sel == PF_SEL_HIGH && i_power_fail) ||
                (i_pf_sel == PF_SEL_LOW && !i_power_fail);
  // Run lengths give minimum holds without long repetitions
  always_ff @(posedge i_ref_clk) begin
    fail_cnt <= (o_sysfail_oe && !i_sys_rst) ? fail_cnt + 1 : 0;
  end
  always_ff @(posedge i_ref_clk) begin
    rst_cnt <= (o_sysreset_oe && !i_sys_rst) ? rst_cnt + 1 : 0;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  a_one_grant: assert property ($onehot0(~o_bus_grant_n))
    else $error("two grants at once");
  a_grant_drop: assert property ((&i_bus_req_n)[*8] |-> &o_bus_grant_n)
    else $error("grant with no request");
  a_berr_hold: assert property (o_berr_oe && stb |=> o_berr_oe)
    else $error("bus error released early");
  a_berr_drop: assert property ((!stb)[*8] |-> !o_berr_oe)
    else $error("bus error kept after strobes");
  a_berr_cause: assert property ($rose(o_berr_oe) |-> stb && $past(stb, 8))
    else $error("bus error without long strobe");
  a_ac_on: assert property (pf_q[*8] |-> o_acfail_oe)
    else $error("power fail not passed on");
  a_ac_off: assert property ((!pf_q)[*8] |-> !o_acfail_oe)
    else $error("acfail without qualified input");
  a_pd_lead: assert property ($rose(o_acfail_oe) && !o_sysreset_oe |=>
    (!o_sysreset_oe)[*8])
    else $error("sysreset without acfail lead");
  a_fail_len: assert property ($fell(o_sysfail_oe) |->
    fail_cnt >= SYSFAIL_CYCLES)
    else $error("sysfail too short");
  a_reset_len: assert property ($fell(o_sysreset_oe) |->
    rst_cnt >= PU_RESET_CYCLES)
    else $error("sysreset too short");
  a_clk_high: assert property ($rose(o_sysclk) |->
    o_sysclk[*6] ##[1:2] !o_sysclk)
    else $error("system clock high phase wrong");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  c_berr: cover property ($rose(o_berr_oe));
  c_grant: cover property ($fell(&o_bus_grant_n));
  c_acfail: cover property ($rose(o_acfail_oe));
endmodule
bind vme_system_controller vme_sysctl_checker #(
  .SYSFAIL_CYCLES(SYSFAIL_CYCLES),
  .PU_RESET_CYCLES(PU_RESET_CYCLES)
) u_chk (.*);
`default_nettype wire

// ---- verif/vme_system_controller_tb_top.sv ----
/*
  Self-checking bench for the system controller and its partner.
  Assumes shortened counts for the power and watchdog times.
*/
`timescale 1ns/100ps
`default_nettype none
module vme_system_controller_tb_top;
  import vme_sysctl_pkg::*;
  localparam int SF = 200;
  localparam int PU = 100;
  localparam int PD = 50;
  localparam int WB = 8;
  logic        ref_clk, sys_rst, pwr_fail, btn_n, rr, wr, rd, start, won;
  logic        busy_n, as_n, dtack_n, berr_n, irq, sysclk;
  logic        berr_oe, ac_oe, srst_oe, sf_oe, sfl;
  logic [1:0]  pf_sel, ds_n, won_lvl;
  logic [3:0]  wd_sel, addr, want, ack_dly, req_n, gnt_n;
  logic [31:0] wdata, rdata, rv;
  int          bad_count, cmp_count, cyc;
  vme_bus_partner u_bus (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .i_want(want), .i_grant_n(gnt_n), .i_start(start), .i_ack_dly(ack_dly),
    .i_berr_oe(berr_oe), .o_req_n(req_n), .o_busy_n(busy_n), .o_as_n(as_n),
    .o_ds_n(ds_n), .o_dtack_n(dtack_n), .o_berr_n(berr_n), .o_won(won),
    .o_won_lvl(won_lvl));
  vme_system_controller #(.SYSFAIL_CYCLES(SF), .PU_RESET_CYCLES(PU),
    .PD_RESET_CYCLES(PD), .WD_BASE_CYCLES(WB)) dut (.i_ref_clk(ref_clk),
    .i_sys_rst(sys_rst), .i_bus_req_n(req_n), .i_bus_busy_n(busy_n),
    .i_addr_strobe_n(as_n), .i_data_strobe_n(ds_n), .i_dtack_n(dtack_n),
    .i_berr_n(berr_n), .i_power_fail(pwr_fail), .i_reset_button_n(btn_n),
    .i_rr_mode(rr), .i_pf_sel(pf_sel), .i_wd_sel(wd_sel), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
    .o_sysclk(sysclk), .o_bus_grant_n(gnt_n), .o_berr_n(),
    .o_berr_oe(berr_oe), .o_acfail_n(), .o_acfail_oe(ac_oe),
    .o_sysreset_n(), .o_sysreset_oe(srst_oe), .o_sysfail_n(),
    .o_sysfail_oe(sf_oe), .o_berr_led(), .o_sysfail_led(sfl));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog clamp case alone needs about 33k cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      give_verdict();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task creg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    rv = rdata;
    check(rv, exp);
  endtask
  task do_reset(input logic r, input logic [1:0] p, input logic [3:0] w);
    @(posedge ref_clk);
    sys_rst  <= 1'b1;
    rr       <= r;
    pf_sel   <= p;
    wd_sel   <= w;
    pwr_fail <= (p == PF_SEL_LOW);
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check(srst_oe, 1'b1);
    check(sf_oe, 1'b1);
    check(sfl, 1'b1);
    repeat (SF + 20) @(negedge ref_clk);
    check(srst_oe, 1'b0);
    check(sf_oe, 1'b0);
  endtask
  task req(input logic [3:0] m);
    @(posedge ref_clk);
    want <= m;
    @(posedge ref_clk);
    want <= 4'h0;
  endtask
  task expect_win(input logic [1:0] lvl);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (won !== 1'b1 && n < 80);
    check({won, won_lvl}, {1'b1, lvl});
  endtask
  task t_regs();
    int n;
    logic prv;
    creg(REG_STATE, 32'h3400);
    creg(REG_IRQ_MASK, 32'h0);
    wreg(REG_IRQ_MASK, 32'hF);
    creg(REG_IRQ_MASK, 32'hF);
    wreg(4'hC, 32'hFFFFFFFF);
    creg(4'hC, 32'h0);
    wreg(REG_IRQ_MASK, 32'h0);
    n = 0;
    prv = sysclk;
    repeat (400) begin
      @(negedge ref_clk);
      n += (sysclk !== prv);
      prv = sysclk;
    end
    check(n >= 63 && n <= 65, 1'b1);
    $display("register and clock test done");
  endtask
  task t_arb();
    req(4'hB);
    expect_win(2'h3);
    expect_win(2'h1);
    expect_win(2'h0);
    do_reset(1'b1, PF_SEL_HIGH, 4'h0);
    creg(REG_STATE, 32'h0600);
    req(4'h4);
    expect_win(2'h2);
    req(4'hA);
    expect_win(2'h1);
    expect_win(2'h3);
    req(4'h9);
    expect_win(2'h0);
    expect_win(2'h3);
    $display("arbiter test done");
  endtask
  task t_wd(input logic [3:0] sel);
    int n;
    int lim;
    do_reset(1'b0, PF_SEL_HIGH, sel);
    wreg(REG_IRQ_MASK, 32'h1);
    lim = WB << ((sel > WD_SEL_MAX) ? WD_SEL_MAX : sel);
    @(posedge ref_clk);
    start <= 1'b1;
    ack_dly <= 4'h0;
    @(posedge ref_clk);
    start <= 1'b0;
    n = 0;
    while (berr_oe !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    check(n >= lim && n <= lim + 12, 1'b1);
    @(negedge ref_clk);
    check(irq, 1'b1);
    repeat (20) @(negedge ref_clk);
    check({berr_oe, as_n}, 2'h1);
    creg(REG_IRQ_STATUS, 32'h1);
    wreg(REG_IRQ_STATUS, 32'h1);
    repeat (2) @(negedge ref_clk);
    check(irq, 1'b0);
    @(posedge ref_clk);
    start <= 1'b1;
    ack_dly <= 4'h3;
    @(posedge ref_clk);
    start <= 1'b0;
    n = 0;
    repeat (lim + 40) @(negedge ref_clk) n += berr_oe;
    check(n, 0);
    creg(REG_IRQ_STATUS, 32'h0);
    $display("watchdog test done");
  endtask
  task t_power();
    logic [1:0] s;
    for (int i = 0; i < 3; i++) begin
      s = (i == 0) ? PF_SEL_LOW : 2'(i * 3 - 3);
      do_reset(1'b0, s, 4'h0);
      @(posedge ref_clk);
      pwr_fail <= ~pwr_fail;
      repeat (10) @(negedge ref_clk);
      check(ac_oe, s == PF_SEL_LOW);
    end
    do_reset(1'b0, PF_SEL_HIGH, 4'h0);
    @(posedge ref_clk);
    pwr_fail <= 1'b1;
    repeat (10) @(negedge ref_clk);
    check({ac_oe, srst_oe, sf_oe}, 3'h5);
    repeat (PD) @(negedge ref_clk);
    check(srst_oe, 1'b1);
    @(posedge ref_clk);
    pwr_fail <= 1'b0;
    repeat (SF + PU) @(negedge ref_clk);
    check({ac_oe, srst_oe, sf_oe}, 3'h0);
    @(posedge ref_clk);
    btn_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    btn_n <= 1'b1;
    repeat (10) @(negedge ref_clk);
    check(sf_oe, 1'b1);
    repeat (SF) @(negedge ref_clk);
    check(sf_oe, 1'b0);
    creg(REG_IRQ_STATUS, 32'hE);
    wreg(REG_IRQ_MASK, 32'h2);
    repeat (2) @(negedge ref_clk);
    check(irq, 1'b1);
    wreg(REG_IRQ_STATUS, 32'h2);
    repeat (2) @(negedge ref_clk);
    check(irq, 1'b0);
    $display("power test done");
  endtask
  initial begin
    sys_rst = 1'b1;
    btn_n   = 1'b1;
    {pwr_fail, rr, wr, rd, start} = 5'h0;
    pf_sel  = PF_SEL_HIGH;
    {wd_sel, addr, want, ack_dly} = 16'h0;
    wdata   = 32'h0;
    do_reset(1'b0, PF_SEL_HIGH, 4'h3);
    t_regs();
    t_arb();
    t_power();
    t_wd(4'h0);
    t_wd(4'h3);
    t_wd(4'hF);
    give_verdict();
  end
endmodule
`default_nettype wire
